//--- timer_single_pulse_capture.sv
// 10-bit standard timer core: compare, pwm, single pulse and capture modes
// assumes control bits are held by software; the count rate is i_count_tick
//
// Functional notes
// RULE1: pwm counting and compare keep running when pin action is 00 or 01.
// RULE2: pwm ignores clear source select; swap bit picks the period register.
// RULE3: mode 10 with pin action 11 selects single pulse output.
// RULE4: a software rise of the run bit starts the pulse.
// RULE5: trigger pin active edge sets the run bit in single pulse mode.
// RULE6: run rising starts the counter and drives the leading edge.
// RULE7: run cleared or compare A match ends the pulse; match clears run.
// RULE8: single pulse compare A match raises the compare A flag.
// RULE9: single pulse counter zeroes only on run rise; P, clear, swap unused.
// RULE10: software keeps pin action at 11 during single pulse mode.
// RULE11: mode 01 is capture; pin action picks rising, falling or both edges.
// RULE12: capture counter starts on run rise and runs until run falls.
// RULE13: each active capture edge copies the counter to compare A, sets flag.
// RULE14: capture P match zeroes the counter, flags; P of zero runs to 3FF.
// RULE15: pin action 11 in capture mode disables capture, counter still runs.
// RULE16: capture has no output; level, invert, clear and swap bits ignored.
// RULE17: counter is 10 bits wide, maximum count 3FF.
// RULE18: output invert bit inverts the timer output pin in compare, pwm and single pulse modes; mode 11 drives the pin low.
// RULE19: each run bit rise returns the output to the initial level; pwm pin action 00 or 01 keeps its forced level instead.
// RULE20: trigger and capture pins are synchronised and edge detected first.
module timer_single_pulse_capture
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // count rate enable
    input wire logic i_count_tick,
    // run bit write
    input wire logic i_run_wr,
    input wire logic i_run_wdata,
    // mode and pin action
    input wire logic i_op_select_hi,
    input wire logic i_op_select_lo,
    input wire logic i_pin_action_hi,
    input wire logic i_pin_action_lo,
    // waveform controls
    input wire logic i_clear_source_sel,
    input wire logic i_duty_period_swap,
    input wire logic i_output_initial_level,
    input wire logic i_output_invert,
    // compare values
    input wire logic i_compare_a_wr,
    input wire logic [CNT_W-1:0] i_compare_a_wdata,
    input wire logic [CMP_P_W-1:0] i_compare_p_value,
    // flag clears
    input wire logic i_match_a_clr,
    input wire logic i_match_p_clr,
    // external pins
    input wire logic i_ext_trigger_pin,
    input wire logic i_capture_input_pin,
    // outputs
    output logic o_timer_out_pin,
    output logic o_counter_run_bit,
    output logic [CNT_W-1:0] o_compare_a_value,
    output logic [CNT_W-1:0] o_count_value,
    output logic o_match_a_flag,
    output logic o_match_p_flag
);

    timer_state_t s_reg;
    timer_state_t s_next;
    edge_if ev ();

    op_mode_t op;
    logic [1:0] pa;
    logic sp_mode;
    logic cap_mode;
    logic run_rise;
    logic tick;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] p_mark;
    logic hit_a;
    logic hit_p;
    logic cap_edge;
    logic clr_cnt;
    logic set_a;
    logic set_p;
    logic [CNT_W:0] duty;

    // -----------------------------------------------------------------
    // pin synchroniser
    // -----------------------------------------------------------------
    // RULE20 sync both pins
    pin_edge_sync u_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_pins({i_capture_input_pin, i_ext_trigger_pin}),
        .ev(ev.src)
    );

    // -----------------------------------------------------------------
    // decode and comparators
    // -----------------------------------------------------------------
    assign op = op_mode_t'({i_op_select_hi, i_op_select_lo});
    assign pa = {i_pin_action_hi, i_pin_action_lo};
    // RULE3 single pulse decode (RULE10 pin action held)
    assign sp_mode = (op == OP_PWM) && (pa == PA_SINGLE);
    // RULE11 capture decode
    assign cap_mode = (op == OP_CAPTURE);
    assign run_rise = s_reg.run & ~s_reg.run_d;
    assign tick = i_count_tick & s_reg.run & ~run_rise;
    // RULE17 ten-bit count wraps after 3FF
    assign cnt_inc = s_reg.count + CNT_ONE;
    assign p_mark = {i_compare_p_value, P_LOW_ZERO};
    assign hit_a = tick & (cnt_inc == s_reg.cmp_a);
    // RULE14 P of zero matches at the wrap only
    assign hit_p = tick & (cnt_inc == p_mark);

    // RULE11 capture edge select
    // RULE15 pin action 11 never captures
    always_comb begin
        case (pa)
            CAP_RISE: cap_edge = cap_mode & ev.rise[PIN_CAP];
            CAP_FALL: cap_edge = cap_mode & ev.fall[PIN_CAP];
            CAP_BOTH: cap_edge = cap_mode & (ev.rise[PIN_CAP] | ev.fall[PIN_CAP]);
            default: cap_edge = 1'b0;
        endcase
    end

    // RULE2 pwm period from swap bit
    // RULE9 single pulse never clears
    always_comb begin
        case (op)
            OP_CAPTURE: clr_cnt = hit_p;
            OP_PWM: clr_cnt = sp_mode ? 1'b0 : (i_duty_period_swap ? hit_a : hit_p);
            default: clr_cnt = i_clear_source_sel ? hit_a : hit_p;
        endcase
    end

    assign duty = i_duty_period_swap
        ? ((i_compare_p_value == '0) ? FULL_PERIOD : {1'b0, p_mark})
        : {1'b0, s_reg.cmp_a};
    // RULE8 single pulse match flags A
    // RULE13 capture flags A
    assign set_a = cap_edge | (hit_a & ~cap_mode);
    assign set_p = hit_p & ~sp_mode & ~((op[0] == op[1]) & i_clear_source_sel);

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.run_d = s_reg.run;
        if (i_run_wr) begin
            s_next.run = i_run_wdata;
        end
        // RULE7 compare A ends pulse
        if (sp_mode && hit_a) begin
            s_next.run = 1'b0;
        end
        // RULE5 trigger sets run
        if (sp_mode && ev.rise[PIN_TRIG]) begin
            s_next.run = 1'b1;
        end
        // RULE12 counter restarts on run rise
        if (run_rise) begin
            s_next.count = CNT_RST;
        end else if (tick) begin
            // RULE1 counting independent of pin action
            s_next.count = clr_cnt ? CNT_RST : cnt_inc;
        end
        if (i_compare_a_wr) begin
            s_next.cmp_a = i_compare_a_wdata;
        end
        // RULE13 latch counter into compare A
        if (cap_edge) begin
            s_next.cmp_a = s_reg.count;
        end
        if (i_match_a_clr) begin
            s_next.flag_a = 1'b0;
        end
        if (set_a) begin
            s_next.flag_a = 1'b1;
        end
        if (i_match_p_clr) begin
            s_next.flag_p = 1'b0;
        end
        if (set_p) begin
            s_next.flag_p = 1'b1;
        end
        case (op)
            OP_PWM: begin
                if (sp_mode) begin
                    // RULE4 RULE6 pulse follows run bit
                    s_next.out_lvl = s_next.run ? i_output_initial_level
                                                : ~i_output_initial_level;
                end else if (pa == PA_FORCE_INACT) begin
                    s_next.out_lvl = ~i_output_initial_level;
                end else if (pa == PA_FORCE_ACT) begin
                    s_next.out_lvl = i_output_initial_level;
                end else if (run_rise) begin
                    s_next.out_lvl = i_output_initial_level;
                end else if (s_reg.run) begin
                    s_next.out_lvl = ({1'b0, s_next.count} < duty)
                        ? i_output_initial_level : ~i_output_initial_level;
                end
            end
            OP_CAPTURE: begin
                s_next.out_lvl = s_reg.out_lvl;
            end
            default: begin
                // RULE19 run rise restores initial level
                if (run_rise) begin
                    s_next.out_lvl = i_output_initial_level;
                end else if (hit_a) begin
                    case (pa)
                        CM_LOW: s_next.out_lvl = 1'b0;
                        CM_HIGH: s_next.out_lvl = 1'b1;
                        CM_TOGGLE: s_next.out_lvl = ~s_reg.out_lvl;
                        default: s_next.out_lvl = s_reg.out_lvl;
                    endcase
                end
            end
        endcase
        // RULE16 no output in capture mode
        // RULE18 output invert
        s_next.pin = (op == OP_CAPTURE || op == OP_TIMER) ? 1'b0
                                                          : s_next.out_lvl ^ i_output_invert;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= TIMER_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_timer_out_pin = s_reg.pin;
    assign o_counter_run_bit = s_reg.run;
    assign o_compare_a_value = s_reg.cmp_a;
    assign o_count_value = s_reg.count;
    assign o_match_a_flag = s_reg.flag_a;
    assign o_match_p_flag = s_reg.flag_p;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    sequence sp_start;
        sp_mode && $past(sp_mode) ##0 $rose(s_reg.run);
    endsequence

    sequence sp_match;
        sp_mode && hit_a && !ev.rise[PIN_TRIG];
    endsequence

    a_sp_trigger_run: assert property ( // RULE5
        sp_mode && ev.rise[PIN_TRIG] |=> s_reg.run)
        else $error("trigger edge did not set run");
    a_sp_leading_edge: assert property ( // RULE6
        sp_start |-> s_reg.pin == (i_output_initial_level ^ i_output_invert)
                     ##1 s_reg.count == CNT_RST)
        else $error("single pulse start wrong");
    a_sp_match_end: assert property ( // RULE7
        sp_match |=> !s_reg.run && s_reg.flag_a
                     && s_reg.pin == $past(~i_output_initial_level ^ i_output_invert))
        else $error("compare A did not end pulse");
    a_sp_count_hold: assert property ( // RULE9
        sp_mode && !s_reg.run && !s_reg.run_d |=> $stable(s_reg.count))
        else $error("single pulse counter moved while stopped");
    a_run_restart: assert property ( // RULE12
        $rose(s_reg.run) |=> s_reg.count == CNT_RST)
        else $error("counter not zeroed on run rise");
    a_cap_latch_count: assert property ( // RULE13
        cap_edge |=> s_reg.cmp_a == $past(s_reg.count) && s_reg.flag_a)
        else $error("capture did not latch counter");
    a_cap_p_wrap: assert property ( // RULE14
        cap_mode && hit_p |=> s_reg.count == CNT_RST && s_reg.flag_p)
        else $error("P match did not wrap counter");
    a_cap_none_edge: assert property ( // RULE15
        cap_mode && pa == CAP_NONE && !i_compare_a_wr |=> $stable(s_reg.cmp_a))
        else $error("capture with edges disabled");
    a_cap_no_output: assert property ( // RULE16
        cap_mode |=> s_reg.pin == 1'b0)
        else $error("capture mode drove the output");
    a_pwm_keeps_count: assert property ( // RULE1
        op == OP_PWM && !sp_mode && tick && !clr_cnt && !i_run_wr
        |=> s_reg.count == $past(cnt_inc))
        else $error("pwm counter stalled");
    a_cnt_top_wrap: assert property ( // RULE17
        tick && s_reg.count == CNT_MAX && !run_rise |=> s_reg.count == CNT_RST)
        else $error("counter did not wrap at 3FF");

    sequence pwm_start;
        op == OP_PWM && pa == PA_PWM ##0 run_rise;
    endsequence

    a_pwm_start_level: assert property ( // RULE19
        pwm_start |=> s_reg.pin == $past(i_output_initial_level ^ i_output_invert))
        else $error("pwm run rise did not restore level");
    a_pwm_swap_period: assert property ( // RULE2
        op == OP_PWM && !sp_mode && i_duty_period_swap && hit_a |=> s_reg.count == CNT_RST)
        else $error("pwm period not set by compare A");
    a_cap_free_run: assert property ( // RULE12
        cap_mode && tick && !hit_p |=> s_reg.count == $past(cnt_inc))
        else $error("capture counter did not free run");
    a_cap_none_flag: assert property ( // RULE15
        cap_mode && pa == CAP_NONE |=> !$rose(s_reg.flag_a))
        else $error("capture flag raised with edges disabled");

endmodule : timer_single_pulse_capture

//--- timer_pkg.sv
// constants, encodings and state types for the single pulse / capture timer
// assumes one clock; the count rate arrives as a one-cycle enable pulse
package timer_pkg;

    // -----------------------------------------------------------------
    // widths and counter constants
    // -----------------------------------------------------------------
    localparam int CNT_W = 10;
    localparam int CMP_P_W = 3;
    localparam int P_LOW_W = 7;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [CNT_W-1:0] CMP_A_RST = 10'h000;
    localparam logic [P_LOW_W-1:0] P_LOW_ZERO = 7'h00;
    localparam logic [CNT_W:0] FULL_PERIOD = 11'h400;

    // -----------------------------------------------------------------
    // pin indices of the synchroniser
    // -----------------------------------------------------------------
    localparam int PIN_TRIG = 0;
    localparam int PIN_CAP = 1;
    localparam int PIN_N = 2;

    // -----------------------------------------------------------------
    // operating modes and pin action encodings
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_COMPARE = 2'h0,
        OP_CAPTURE = 2'h1,
        OP_PWM = 2'h2,
        OP_TIMER = 2'h3
    } op_mode_t;

    // pwm / single pulse pin action
    localparam logic [1:0] PA_FORCE_INACT = 2'h0;
    localparam logic [1:0] PA_FORCE_ACT = 2'h1;
    localparam logic [1:0] PA_PWM = 2'h2;
    localparam logic [1:0] PA_SINGLE = 2'h3;
    // capture edge select
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;
    localparam logic [1:0] CAP_NONE = 2'h3;
    // compare match pin action
    localparam logic [1:0] CM_NONE = 2'h0;
    localparam logic [1:0] CM_LOW = 2'h1;
    localparam logic [1:0] CM_HIGH = 2'h2;
    localparam logic [1:0] CM_TOGGLE = 2'h3;

    // -----------------------------------------------------------------
    // state records
    // -----------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic run_d;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] cmp_a;
        logic out_lvl;
        logic pin;
        logic flag_a;
        logic flag_p;
    } timer_state_t;

    localparam timer_state_t TIMER_RST = '{
        run: 1'b0, run_d: 1'b0, count: CNT_RST, cmp_a: CMP_A_RST,
        out_lvl: 1'b0, pin: 1'b0, flag_a: 1'b0, flag_p: 1'b0};

    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
    } edge_state_t;

    localparam edge_state_t EDGE_RST = '{s1: 2'h0, s2: 2'h0, s3: 2'h0};

endpackage : timer_pkg

//--- edge_if.sv
// edge events passed from the pin synchroniser to the timer core
// assumes both ends share i_clock
interface edge_if;
    logic [timer_pkg::PIN_N-1:0] rise;
    logic [timer_pkg::PIN_N-1:0] fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface : edge_if

//--- pin_edge_sync.sv
// two-stage synchroniser and edge detector for the trigger and capture pins
// assumes pins are asynchronous levels; edges come out one cycle wide
module pin_edge_sync
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // raw pins
    input wire logic [PIN_N-1:0] i_pins,
    // edge events
    edge_if.src ev
);

    edge_state_t s_reg;
    edge_state_t s_next;

    // -----------------------------------------------------------------
    // shift chain; s1 feeds only s2
    // -----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.s1 = i_pins;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= EDGE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // RULE20 edge detect after sync
    for (genvar g = 0; g < PIN_N; g++) begin : g_edge
        assign ev.rise[g] = s_reg.s2[g] & ~s_reg.s3[g];
        assign ev.fall[g] = ~s_reg.s2[g] & s_reg.s3[g];
    end

endmodule : pin_edge_sync

//--- pin_partner.sv
// far-side model driving the external trigger and capture input pins
// assumes bench requests change just after a rising edge of i_clock
module pin_partner (
    // clock
    input wire logic i_clock,
    // bench requests
    input wire logic i_trig_go,
    input wire logic i_cap_lvl,
    // pins
    output logic o_ext_trigger_pin,
    output logic o_capture_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    int hold_cnt = 0;

    always @(posedge i_clock) begin
        if (i_trig_go) begin
            hold_cnt = 4;
        end
        else if (hold_cnt > 0) begin
            hold_cnt--;
        end
        #2 o_ext_trigger_pin = (hold_cnt > 0);
    end

    // capture level lands off the clock edge
    assign #1.3 o_capture_input_pin = i_cap_lvl;

endmodule : pin_partner

//--- testbench.sv
// self-checking bench for the single pulse / capture timer core
// assumes pin_partner drives the trigger and capture pins
module testbench
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clock = 1'b0, i_rst_b = 1'b0, i_count_tick = 1'b0;
    logic i_run_wr = 1'b0, i_run_wdata = 1'b0, i_compare_a_wr = 1'b0;
    logic i_op_select_hi = 1'b0, i_op_select_lo = 1'b0;
    logic i_pin_action_hi = 1'b0, i_pin_action_lo = 1'b0;
    logic i_clear_source_sel = 1'b0, i_duty_period_swap = 1'b0;
    logic i_output_initial_level = 1'b0, i_output_invert = 1'b0;
    logic [CNT_W-1:0] i_compare_a_wdata = 10'h000;
    logic [CMP_P_W-1:0] i_compare_p_value = 3'h0;
    logic i_match_a_clr = 1'b0, i_match_p_clr = 1'b0, trig_go = 1'b0, cap_lvl = 1'b0;
    logic trig_pin, cap_pin, o_timer_out_pin, o_counter_run_bit, o_match_a_flag, o_match_p_flag;
    logic [CNT_W-1:0] o_compare_a_value, o_count_value, c;
    logic lvl;
    int error_cnt = 0;
    int n_compared = 0;

    always #2.5 i_clock = ~i_clock;

    pin_partner partner (.i_clock(i_clock), .i_trig_go(trig_go), .i_cap_lvl(cap_lvl),
        .o_ext_trigger_pin(trig_pin), .o_capture_input_pin(cap_pin));

    timer_single_pulse_capture DUT (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_count_tick(i_count_tick), .i_run_wr(i_run_wr), .i_run_wdata(i_run_wdata),
        .i_op_select_hi(i_op_select_hi), .i_op_select_lo(i_op_select_lo),
        .i_pin_action_hi(i_pin_action_hi), .i_pin_action_lo(i_pin_action_lo),
        .i_clear_source_sel(i_clear_source_sel), .i_duty_period_swap(i_duty_period_swap),
        .i_output_initial_level(i_output_initial_level), .i_output_invert(i_output_invert),
        .i_compare_a_wr(i_compare_a_wr), .i_compare_a_wdata(i_compare_a_wdata),
        .i_compare_p_value(i_compare_p_value), .i_match_a_clr(i_match_a_clr),
        .i_match_p_clr(i_match_p_clr), .i_ext_trigger_pin(trig_pin),
        .i_capture_input_pin(cap_pin), .o_timer_out_pin(o_timer_out_pin),
        .o_counter_run_bit(o_counter_run_bit), .o_compare_a_value(o_compare_a_value),
        .o_count_value(o_count_value), .o_match_a_flag(o_match_a_flag),
        .o_match_p_flag(o_match_p_flag));

    // -----------------------------------------------------------------
    // access tasks
    // -----------------------------------------------------------------
    task automatic end_sim();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end
        else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic step();
        @(posedge i_clock);
        #1;
    endtask : step

    task automatic tick(input int n);
        repeat (n) step();
    endtask : tick

    task automatic chk(input string nm, input logic [CNT_W-1:0] exp,
                       input logic [CNT_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic set_run(input logic v);
        i_run_wr = 1'b1;
        i_run_wdata = v;
        step();
        i_run_wr = 1'b0;
    endtask : set_run

    task automatic wr_a(input logic [CNT_W-1:0] v);
        i_compare_a_wr = 1'b1;
        i_compare_a_wdata = v;
        step();
        i_compare_a_wr = 1'b0;
    endtask : wr_a

    task automatic clr_flags();
        i_match_a_clr = 1'b1;
        i_match_p_clr = 1'b1;
        step();
        i_match_a_clr = 1'b0;
        i_match_p_clr = 1'b0;
    endtask : clr_flags

    task automatic set_mode(input op_mode_t m, input logic [1:0] a);
        {i_op_select_hi, i_op_select_lo} = m;
        {i_pin_action_hi, i_pin_action_lo} = a;
    endtask : set_mode

    function automatic logic sig(input int w);
        case (w)
            0: return o_counter_run_bit;
            1: return o_match_a_flag;
            2: return o_match_p_flag;
            3: return o_count_value === CNT_MAX;
            default: return !o_counter_run_bit;
        endcase
    endfunction : sig

    task automatic wait_on(input int w, input int lim);
        int n;
        n = 0;
        while (sig(w) !== 1'b1) begin
            if (n == lim) begin
                error_cnt++;
                $display("[FAIL] wait %0d expected 1 seen timeout", w);
                end_sim();
            end
            step();
            n++;
        end
    endtask : wait_on

    // -----------------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_clock);
        #1 i_rst_b = 1'b1;
        i_count_tick = 1'b1;
        chk("rst_count", 0, o_count_value);
        chk("rst_pin", 0, o_timer_out_pin);
        set_mode(OP_PWM, PA_SINGLE);
        i_output_initial_level = 1'b1;
        i_compare_p_value = 3'h2;
        i_clear_source_sel = 1'b1;
        i_duty_period_swap = 1'b1;
        for (int k = 0; k < 2; k++) begin
            i_output_invert = k[0];
            lvl = ~k[0];
            wr_a(10'h014);
            clr_flags();
            set_run(1'b1);
            chk("sp_run", 1, o_counter_run_bit);
            chk("sp_lead", lvl, o_timer_out_pin);
            step();
            chk("sp_zero", 0, o_count_value);
            wait_on(4, 100);
            chk("sp_width", 10'h014, o_count_value);
            chk("sp_trail", !lvl, o_timer_out_pin);
            chk("sp_flag_a", 1, o_match_a_flag);
            chk("sp_flag_p", 0, o_match_p_flag);
            wr_a(10'h0C8);
            clr_flags();
            set_run(1'b1);
            tick(10);
            set_run(1'b0);
            chk("sw_trail", !lvl, o_timer_out_pin);
            c = o_count_value;
            tick(3);
            chk("sw_hold", c, o_count_value);
            chk("sw_flag_a", 0, o_match_a_flag);
            trig_go = 1'b1;
            step();
            trig_go = 1'b0;
            wait_on(0, 10);
            chk("tr_lead", lvl, o_timer_out_pin);
            step();
            chk("tr_zero", 0, o_count_value);
            wait_on(4, 300);
            chk("tr_flag_a", 1, o_match_a_flag);
        end
        set_mode(OP_CAPTURE, CAP_RISE);
        i_compare_p_value = 3'h1;
        set_run(1'b1);
        for (int a = 0; a < 4; a++) begin
            {i_pin_action_hi, i_pin_action_lo} = a[1:0];
            clr_flags();
            cap_lvl = 1'b1;
            tick(2);
            c = o_count_value;
            tick(6);
            if (a[0] == 1'b0) chk("cap_rise_val", c, o_compare_a_value);
            chk("cap_rise", (a == 0 || a == 2), o_match_a_flag);
            chk("cap_range", 1, o_compare_a_value < 10'h080);
            chk("cap_pin", 0, o_timer_out_pin);
            clr_flags();
            cap_lvl = 1'b0;
            tick(2);
            c = o_count_value;
            tick(6);
            if (a == 1 || a == 2) chk("cap_fall_val", c, o_compare_a_value);
            chk("cap_fall", (a == 1 || a == 2), o_match_a_flag);
        end
        clr_flags();
        wait_on(2, 140);
        chk("p_wrap", 1, o_count_value < 10'h002);
        i_compare_p_value = 3'h0;
        wait_on(3, 1100);
        step();
        chk("max_wrap", 0, o_count_value);
        set_run(1'b0);
        c = o_count_value;
        tick(4);
        chk("cap_stop", c, o_count_value);
        set_mode(OP_PWM, PA_FORCE_INACT);
        i_output_invert = 1'b0;
        i_duty_period_swap = 1'b0;
        i_compare_p_value = 3'h1;
        set_run(1'b1);
        tick(2);
        chk("pwm_inact", 0, o_timer_out_pin);
        clr_flags();
        wait_on(2, 300);
        set_mode(OP_PWM, PA_FORCE_ACT);
        tick(2);
        chk("pwm_act", 1, o_timer_out_pin);
        set_run(1'b0);
        i_duty_period_swap = 1'b1;
        wr_a(10'h032);
        set_run(1'b1);
        clr_flags();
        wait_on(1, 300);
        c = 10'h000;
        repeat (120) begin
            step();
            if (o_count_value > c) c = o_count_value;
        end
        chk("pwm_period", 1, c <= 10'h032);
        chk("pwm_no_p", 0, o_match_p_flag);
        set_run(1'b0);
        i_duty_period_swap = 1'b0;
        set_mode(OP_PWM, PA_PWM);
        tick(1);
        set_run(1'b1);
        clr_flags();
        wait_on(2, 300);
        chk("pwm_active", 1, o_timer_out_pin);
        tick(64);
        chk("pwm_inactive", 0, o_timer_out_pin);
        end_sim();
    end

endmodule : testbench
